/* File: src/vsfr_top.sv */
// Purpose: Framing supervision and recovery between two video streams.
// Assumes: One clock; upstream and downstream share it.
// Notes:   Output beats are registered one stage; the sample word passes
//          unchanged, only markers are regenerated.
//
// How it works
// - Without the bus, fixed default size and format are used.
// - From a known state, configured size predicts next frame start.
// - Configured line length predicts each line's final pixel.
// - Early/missing frame start and early/missing line end are errors.
// - Early input frame start ends current output frame at once.
// - Late frame start: drop input until it comes, then output it.
// - Early input line end emits output line end immediately.
// - Late line end: output it on schedule, drop pixels until it comes; on a frame's last line, until next frame start.
// - Status shows busy, idle-after-last-frame and activity.
// - Everything runs from the single clock clk.
// - Stream carries 4:4:4, 4:2:2 or 4:2:0 samples.
// - Error bits: 0 early line end, 1 late, 2 early frame, 3 late.
// - Frame start on user bit 0, line end on last, both sides.
// - Input ready low during init, then rises once enable is set; while flushing, high except for a frame start waiting for output room.
`include "vsfr_cfg.svh"

module vsfr_top #(
    parameter logic USE_BUS    = 1'b1,
    parameter int   DATA_WIDTH = 24
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic [DATA_WIDTH-1:0] s_axis_tdata,
    input  wire logic                  s_axis_tvalid,
    output logic                       s_axis_tready,
    input  wire logic                  s_axis_tuser,
    input  wire logic                  s_axis_tlast,
    output logic      [DATA_WIDTH-1:0] m_axis_tdata,
    output logic                       m_axis_tvalid,
    input  wire logic                  m_axis_tready,
    output logic                       m_axis_tuser,
    output logic                       m_axis_tlast,
    output logic      [3:0]            error_flags
);

    typedef enum logic [1:0] {
        VSFR_INIT,
        VSFR_RUN,
        VSFR_FLUSH_LINE,
        VSFR_FLUSH_FRAME
    } vsfr_state_t;

    vsfr_state_t            state;
    vsfr_pkg::vsfr_size_t   size;
    logic                   enable;
    logic                   sw_reset;
    logic [3:0]             err_set;
    logic [2:0]             status;
    logic [4:0]             init_cnt;
    logic [12:0]            pix;
    logic [12:0]            line;
    logic                   synced;
    logic                   out_free;
    logic                   in_fire;
    logic                   in_sof;
    logic                   in_line_end;
    logic                   late_sof;
    logic                   last_pix;
    logic                   last_line;
    logic                   frame_done;

    vsfr_wb_regs #(
        .USE_BUS (USE_BUS)
    ) u_regs (
        .clk      (clk),
        .rst_n    (rst_n),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .err_set  (err_set),
        .status   (status),
        .enable   (enable),
        .sw_reset (sw_reset),
        .size     (size),
        .errors   (error_flags)
    );

    // Output register can accept when empty or being drained
    assign out_free = !m_axis_tvalid || m_axis_tready;

    always_comb begin
        s_axis_tready = 1'b0;
        case (state)
            VSFR_INIT:        s_axis_tready = 1'b0;
            VSFR_RUN:         s_axis_tready = out_free && enable;
            // Dropped beats need no room; a frame start is forwarded
            VSFR_FLUSH_LINE:  s_axis_tready = !s_axis_tuser || out_free;
            VSFR_FLUSH_FRAME: s_axis_tready = !s_axis_tuser || out_free;
            default:          s_axis_tready = 1'b0;
        endcase
    end

    assign in_fire   = s_axis_tvalid && s_axis_tready;
    assign in_sof    = s_axis_tuser;
    assign in_line_end = s_axis_tlast;
    assign last_pix  = pix == size.pixels - 13'h0001;
    assign last_line = line == size.lines - 13'h0001;
    assign frame_done = in_fire && state == VSFR_RUN && last_pix
                        && last_line;
    // First beat of a frame without its start marker
    assign late_sof  = in_fire && synced && state == VSFR_RUN && !in_sof
                       && pix == 13'h0000 && line == 13'h0000;

    // Init window after reset or soft reset; ready stays low through it
    always_ff @(posedge clk) begin
        if (!rst_n || sw_reset) begin
            init_cnt <= 5'h00;
        end else if (state == VSFR_INIT && init_cnt != 5'h1F) begin
            init_cnt <= init_cnt + 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || sw_reset) begin
            state <= VSFR_INIT;
        end else begin
            case (state)
                VSFR_INIT: begin
                    if (init_cnt >= 5'(`VSFR_INIT_CYCLES - 1)) begin
                        state <= VSFR_RUN;
                    end
                end
                VSFR_RUN: begin
                    if (late_sof) begin
                        state <= VSFR_FLUSH_FRAME;
                    end else if (in_fire && synced && !in_sof
                                 && !in_line_end && last_pix) begin
                        state <= last_line ? VSFR_FLUSH_FRAME
                                           : VSFR_FLUSH_LINE;
                    end
                end
                VSFR_FLUSH_LINE: begin
                    if (in_fire && in_sof) begin
                        state <= VSFR_RUN;
                    end else if (in_fire && in_line_end) begin
                        state <= VSFR_RUN;
                    end
                end
                VSFR_FLUSH_FRAME: begin
                    if (in_fire && in_sof) begin
                        state <= VSFR_RUN;
                    end
                end
                default: state <= VSFR_INIT;
            endcase
        end
    end

    // Pixel and line position of the next accepted input beat
    always_ff @(posedge clk) begin
        if (!rst_n || sw_reset) begin
            pix    <= 13'h0000;
            line   <= 13'h0000;
            synced <= 1'b0;
        end else if (in_fire) begin
            if (in_sof) begin
                synced <= 1'b1;
                line   <= 13'h0000;
                pix    <= (in_line_end || last_pix) ? 13'h0000 : 13'h0001;
                if (in_line_end || last_pix) line <= 13'h0001;
            end else if (state == VSFR_FLUSH_LINE) begin
                if (in_line_end) pix <= 13'h0000;
            end else if (state == VSFR_RUN && !late_sof) begin
                if (in_line_end || last_pix) begin
                    pix  <= 13'h0000;
                    line <= last_line ? 13'h0000 : line + 13'h0001;
                end else begin
                    pix <= pix + 13'h0001;
                end
            end
        end
    end

    // Error detection; flags are made sticky in the register block
    always_comb begin
        err_set = 4'h0;
        if (in_fire && synced) begin
            if (state == VSFR_RUN && in_line_end && !last_pix) begin
                err_set[`VSFR_ERR_LINE_EARLY] = 1'b1;
            end
            if (state == VSFR_RUN && !in_line_end && last_pix
                && !in_sof) begin
                err_set[`VSFR_ERR_LINE_LATE] = 1'b1;
            end
            if (in_sof && !(pix == 13'h0000 && line == 13'h0000)
                && state != VSFR_FLUSH_FRAME) begin
                err_set[`VSFR_ERR_SOF_EARLY] = 1'b1;
            end
            if (late_sof) begin
                err_set[`VSFR_ERR_SOF_LATE] = 1'b1;
            end
        end
    end

    // Output stage: markers regenerated from the expected position
    always_ff @(posedge clk) begin
        if (!rst_n || sw_reset) begin
            m_axis_tvalid <= 1'b0;
            m_axis_tuser  <= 1'b0;
            m_axis_tlast  <= 1'b0;
            m_axis_tdata  <= '0;
        end else if (in_fire && ((state == VSFR_RUN && !late_sof)
                                 || in_sof)) begin
            m_axis_tvalid <= 1'b1;
            m_axis_tdata  <= s_axis_tdata;
            // Early start opens a new frame at once; a late one is forwarded after the dropped beats
            m_axis_tuser  <= in_sof;
            // Early end cuts the line; late end is put on schedule
            m_axis_tlast  <= in_line_end || last_pix;
        end else if (m_axis_tready) begin
            m_axis_tvalid <= 1'b0;
        end
    end

    // Done: a frame completed and no input accepted since
    always_ff @(posedge clk) begin
        if (!rst_n || sw_reset) begin
            status <= 3'h0;
        end else begin
            status[`VSFR_STAT_BUSY]   <= state != VSFR_RUN || m_axis_tvalid
                                         || pix != 13'h0000
                                         || line != 13'h0000;
            if (frame_done) begin
                status[`VSFR_STAT_DONE] <= 1'b1;
            end else if (in_fire) begin
                status[`VSFR_STAT_DONE] <= 1'b0;
            end
            status[`VSFR_STAT_ACTIVE] <= enable && synced;
        end
    end

endmodule : vsfr_top

/* File: common/vsfr_cfg.svh */
// Purpose: Offsets, field positions, reset values and counts for the
//          framing supervisor.
// Assumes: Included by bare name; definitions only.
// Notes:   Registers are 32-bit words on classic Wishbone.
`ifndef VSFR_CFG_SVH
`define VSFR_CFG_SVH

`define VSFR_OFF_CONTROL    8'h00
`define VSFR_OFF_STATUS     8'h04
`define VSFR_OFF_ERROR      8'h08
`define VSFR_OFF_SIZE       8'h0C
`define VSFR_OFF_FORMAT     8'h10

`define VSFR_CTRL_ENABLE    0
`define VSFR_CTRL_SWRESET   1

`define VSFR_STAT_BUSY      0
`define VSFR_STAT_DONE      1
`define VSFR_STAT_ACTIVE    2

`define VSFR_ERR_LINE_EARLY 0
`define VSFR_ERR_LINE_LATE  1
`define VSFR_ERR_SOF_EARLY  2
`define VSFR_ERR_SOF_LATE   3

`define VSFR_INIT_CYCLES    16
`define VSFR_RST_MIN_CYCLES 32

`define VSFR_DEF_PIXELS     13'h0780
`define VSFR_DEF_LINES      13'h0438
`define VSFR_DEF_FORMAT     2'h1

`endif

/* File: common/vsfr_pkg.sv */
// Purpose: Types shared by the framing supervisor files.
// Assumes: Used as vsfr_pkg::name, never imported.
// Notes:   Stream beat carries marker sideband beside the sample word.
package vsfr_pkg;

    typedef enum logic [1:0] {
        VSFR_FMT_444,
        VSFR_FMT_422,
        VSFR_FMT_420
    } vsfr_fmt_t;

    typedef struct packed {
        logic [23:0] data;
        logic        sof;
        logic        line_end;
    } vsfr_beat_t;

    typedef struct packed {
        logic [12:0] pixels;
        logic [12:0] lines;
        logic [1:0]  fmt;
    } vsfr_size_t;

endpackage : vsfr_pkg

/* File: src/vsfr_wb_regs.sv */
// Purpose: Wishbone classic slave holding control, size and error bits.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Ack is one cycle after the strobe and drops the cycle after.
`include "vsfr_cfg.svh"

module vsfr_wb_regs #(
    parameter logic USE_BUS = 1'b1
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic [3:0]          err_set,
    input  wire logic [2:0]          status,
    output logic                     enable,
    output logic                     sw_reset,
    output vsfr_pkg::vsfr_size_t     size,
    output logic      [3:0]          errors
);

    logic req;
    logic wr;
    logic [31:0] rd;
    logic [3:0]  err_clr;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr  = req && wb_we_i;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // Fixed configuration when the bus is left out at build time
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable      <= !USE_BUS;
            size.pixels <= `VSFR_DEF_PIXELS;
            size.lines  <= `VSFR_DEF_LINES;
            size.fmt    <= `VSFR_DEF_FORMAT;
        end else if (USE_BUS && wr) begin
            if (wb_adr_i == `VSFR_OFF_CONTROL && wb_sel_i[0]) begin
                enable <= wb_dat_i[`VSFR_CTRL_ENABLE];
            end
            if (wb_adr_i == `VSFR_OFF_SIZE) begin
                if (wb_sel_i[0]) size.pixels[7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) size.pixels[12:8] <= wb_dat_i[12:8];
                if (wb_sel_i[2]) size.lines[7:0]   <= wb_dat_i[23:16];
                if (wb_sel_i[3]) size.lines[12:8]  <= wb_dat_i[28:24];
            end
            if (wb_adr_i == `VSFR_OFF_FORMAT && wb_sel_i[0]
                && wb_dat_i[1:0] != 2'h3) begin
                size.fmt <= wb_dat_i[1:0];
            end
        end
    end

    // Self-clearing; one pulse per write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sw_reset <= 1'b0;
        end else begin
            sw_reset <= wr && wb_adr_i == `VSFR_OFF_CONTROL && wb_sel_i[0]
                        && wb_dat_i[`VSFR_CTRL_SWRESET];
        end
    end

    // Write one to clear; a new event in the same cycle wins
    assign err_clr = (wr && wb_adr_i == `VSFR_OFF_ERROR && wb_sel_i[0])
                     ? wb_dat_i[3:0] : 4'h0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            errors <= 4'h0;
        end else begin
            errors <= (errors & ~err_clr) | err_set;
        end
    end

    always_comb begin
        rd = 32'h0000_0000;
        case (wb_adr_i)
            `VSFR_OFF_CONTROL: rd[0] = enable;
            `VSFR_OFF_STATUS:  rd[2:0] = status;
            `VSFR_OFF_ERROR:   rd[3:0] = errors;
            `VSFR_OFF_SIZE:    rd = {3'h0, size.lines, 3'h0, size.pixels};
            `VSFR_OFF_FORMAT:  rd[1:0] = size.fmt;
            default:           rd = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= rd;
        end
    end

endmodule : vsfr_wb_regs

/* File: tb/vsfr_top_sva.sv */
// Purpose: Port-level checks for the framing supervisor.
// Assumes: One clock, synchronous active-low reset.
// Notes:   The error copy may lag its cause, so causes look back 4 cycles.
module vsfr_top_chk #(
    parameter int DATA_WIDTH = 24
) (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_ack_o,
    input wire logic [DATA_WIDTH-1:0] s_axis_tdata,
    input wire logic                  s_axis_tvalid,
    input wire logic                  s_axis_tready,
    input wire logic                  s_axis_tuser,
    input wire logic                  s_axis_tlast,
    input wire logic [DATA_WIDTH-1:0] m_axis_tdata,
    input wire logic                  m_axis_tvalid,
    input wire logic                  m_axis_tready,
    input wire logic                  m_axis_tuser,
    input wire logic                  m_axis_tlast,
    input wire logic [3:0]            error_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc_line_end;
    logic acc_sof;
    assign acc_line_end = s_axis_tvalid && s_axis_tready && s_axis_tlast;
    assign acc_sof = s_axis_tvalid && s_axis_tready && s_axis_tuser;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o)
        else $error("bus request not answered");
    a_init_ready: assert property ($rose(rst_n) |-> !s_axis_tready [*8])
        else $error("input ready during init");
    a_out_hold: assert property (m_axis_tvalid && !m_axis_tready |=>
        m_axis_tvalid && $stable(m_axis_tdata) && $stable(m_axis_tuser)
        && $stable(m_axis_tlast)) else $error("stalled beat changed");
    a_sof_forward: assert property (acc_sof |=>
        m_axis_tvalid && m_axis_tuser
        && m_axis_tdata == $past(s_axis_tdata)) else $error("start lost");
    a_err_sticky: assert property (!wb_cyc_i && !$past(wb_cyc_i) |=>
        (error_flags & $past(error_flags)) == $past(error_flags))
        else $error("error flag fell");
    a_line_cause: assert property ($rose(error_flags[0]) |->
        $past(acc_line_end) || $past(acc_line_end, 2)
        || $past(acc_line_end, 3) || $past(acc_line_end, 4))
        else $error("early line flag without line end");
    a_sof_cause: assert property ($rose(error_flags[2]) |->
        $past(acc_sof) || $past(acc_sof, 2)
        || $past(acc_sof, 3) || $past(acc_sof, 4))
        else $error("early frame flag without start");
endmodule : vsfr_top_chk

bind vsfr_top vsfr_top_chk #(.DATA_WIDTH(DATA_WIDTH)) u_chk (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .s_axis_tdata(s_axis_tdata),
    .s_axis_tvalid(s_axis_tvalid), .s_axis_tready(s_axis_tready),
    .s_axis_tuser(s_axis_tuser), .s_axis_tlast(s_axis_tlast),
    .m_axis_tdata(m_axis_tdata), .m_axis_tvalid(m_axis_tvalid),
    .m_axis_tready(m_axis_tready), .m_axis_tuser(m_axis_tuser),
    .m_axis_tlast(m_axis_tlast), .error_flags(error_flags));

/* File: tb/vsfr_sink.sv */
// Purpose: Downstream video core model counting beats and markers.
// Assumes: Shares clk and rst_n with the supervisor.
// Notes:   With slow set it refuses one cycle in four.
module vsfr_sink (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        slow,
    input  wire logic        tvalid,
    input  wire logic        tuser,
    input  wire logic        tlast,
    output logic             tready,
    output logic      [15:0] n_beats,
    output logic      [15:0] n_sof,
    output logic      [15:0] n_last,
    output logic      [15:0] line_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  phase;
    logic [15:0] run;
    assign tready = !(slow && phase == 2'h3);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase    <= 2'h0;
            n_beats  <= 16'h0000;
            n_sof    <= 16'h0000;
            n_last   <= 16'h0000;
            run      <= 16'h0000;
            line_len <= 16'h0000;
        end else begin
            phase <= phase + 2'h1;
            if (tvalid && tready) begin
                n_beats <= n_beats + 16'h0001;
                n_sof   <= n_sof + {15'h0000, tuser};
                run     <= tlast ? 16'h0000 : run + 16'h0001;
                if (tlast) begin
                    n_last   <= n_last + 16'h0001;
                    line_len <= run + 16'h0001;
                end
            end
        end
    end
endmodule : vsfr_sink

/* File: tb/vsfr_top_tb.sv */
// Purpose: Self-checking bench for the framing supervisor.
// Assumes: Frames shrunk to 4 pixels by 2 lines over the bus.
// Notes:   Output stalls from the sink cover the hold path.
`include "vsfr_cfg.svh"
module vsfr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [7:0]  adr;
        logic [31:0] wdat;
        logic [31:0] exp;
    } vsfr_row_t;
    logic        clk, rst_n, cyc, stb, we, ack, slow;
    logic        s_valid, s_ready, s_user, s_last;
    logic        m_valid, m_ready, m_user, m_last;
    logic [7:0]  adr;
    logic [3:0]  sel, err;
    logic [31:0] wdat, rdat, q;
    logic [23:0] s_data, m_data;
    logic [15:0] n_beats, n_sof, n_last, line_len;
    int          fail_count, n_tests, cycles, px;
    vsfr_row_t   rows [6] = '{
        '{`VSFR_OFF_SIZE, 32'h0002_0004, 32'h0002_0004},
        '{`VSFR_OFF_FORMAT, 32'h0000_0000, 32'h0000_0000},
        '{`VSFR_OFF_FORMAT, 32'h0000_0001, 32'h0000_0001},
        '{`VSFR_OFF_FORMAT, 32'h0000_0002, 32'h0000_0002},
        '{`VSFR_OFF_FORMAT, 32'h0000_0003, 32'h0000_0002},
        '{8'h20, 32'hFFFF_FFFF, 32'h0000_0000}};

    vsfr_top #(.USE_BUS(1'b1), .DATA_WIDTH(24)) uut (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .s_axis_tdata(s_data),
        .s_axis_tvalid(s_valid), .s_axis_tready(s_ready),
        .s_axis_tuser(s_user), .s_axis_tlast(s_last),
        .m_axis_tdata(m_data), .m_axis_tvalid(m_valid),
        .m_axis_tready(m_ready), .m_axis_tuser(m_user),
        .m_axis_tlast(m_last), .error_flags(err));
    vsfr_sink sink (.clk(clk), .rst_n(rst_n), .slow(slow),
        .tvalid(m_valid), .tuser(m_user), .tlast(m_last), .tready(m_ready),
        .n_beats(n_beats), .n_sof(n_sof), .n_last(n_last),
        .line_len(line_len));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count = fail_count + 1;
            test_done();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : bus

    // Valid stays up across calls so back-to-back lines need no gap
    task automatic send(input int n, input logic u, input logic l);
        for (int i = 0; i < n; i++) begin
            s_valid <= 1'b1;
            s_data <= 24'(px);
            s_user <= u && i == 0;
            s_last <= l && i == n - 1;
            px = px + 1;
            @(posedge clk);
            while (s_ready !== 1'b1) @(posedge clk);
        end
    endtask : send

    task automatic settle(input int n);
        s_valid <= 1'b0;
        while (n_beats !== 16'(n)) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask : settle

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    initial begin
        rst_n = 1'b0;
        {cyc, stb, we, slow, s_valid, s_user, s_last} = 7'h00;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0;
        s_data = 24'h0;
        repeat (32) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check("ready in init", {31'h0, s_ready}, 32'h0);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, rows[i].adr, rows[i].wdat);
            bus(1'b0, rows[i].adr, 32'h0);
            check("register", q, rows[i].exp);
        end
        bus(1'b1, `VSFR_OFF_CONTROL, 32'h0000_0001);
        send(4, 1'b1, 1'b1);
        send(4, 1'b0, 1'b1);
        settle(8);
        check("starts", {16'h0, n_sof}, 32'h1);
        check("line ends", {16'h0, n_last}, 32'h2);
        check("flags clean", {28'h0, err}, 32'h0);
        bus(1'b0, `VSFR_OFF_STATUS, 32'h0);
        check("status done", q, 32'h6);
        bus(1'b1, `VSFR_OFF_CONTROL, 32'h0000_0003);
        check("ready in soft init", {31'h0, s_ready}, 32'h0);
        slow <= 1'b1;
        send(2, 1'b1, 1'b1);
        settle(10);
        check("short line", {16'h0, line_len}, 32'h2);
        check("flags", {28'h0, err}, 32'h1);
        send(6, 1'b0, 1'b1);
        settle(14);
        check("long line", {16'h0, line_len}, 32'h4);
        check("flags", {28'h0, err}, 32'h3);
        send(4, 1'b1, 1'b1);
        send(4, 1'b1, 1'b1);
        send(4, 1'b0, 1'b1);
        settle(26);
        check("starts", {16'h0, n_sof}, 32'h4);
        check("flags", {28'h0, err}, 32'h7);
        send(4, 1'b0, 1'b1);
        send(4, 1'b1, 1'b1);
        send(4, 1'b0, 1'b1);
        settle(34);
        check("beats", {16'h0, n_beats}, 32'h22);
        check("line ends", {16'h0, n_last}, 32'h9);
        check("flags", {28'h0, err}, 32'hF);
        bus(1'b1, `VSFR_OFF_ERROR, 32'h0000_000F);
        bus(1'b0, `VSFR_OFF_ERROR, 32'h0);
        check("error reg", q, 32'h0);
        repeat (2) @(posedge clk);
        check("flags", {28'h0, err}, 32'h0);
        send(6, 1'b1, 1'b1);
        send(4, 1'b0, 1'b1);
        settle(42);
        check("flushed line", {16'h0, line_len}, 32'h4);
        check("line ends", {16'h0, n_last}, 32'hB);
        check("flags", {28'h0, err}, 32'h2);
        send(3, 1'b1, 1'b0);
        rst_n <= 1'b0;
        s_valid <= 1'b0;
        repeat (32) @(posedge clk);
        check("valid in reset", {31'h0, m_valid}, 32'h0);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check("ready in init", {31'h0, s_ready}, 32'h0);
        bus(1'b0, `VSFR_OFF_SIZE, 32'h0);
        check("size", q, {3'h0, `VSFR_DEF_LINES,
                          3'h0, `VSFR_DEF_PIXELS});
        test_done();
    end
endmodule : vsfr_top_tb
